// ===== rtl/meter_pkg.sv
// Constants, register map and types of the measurement select and scale core
package meter_pkg;

    typedef enum logic [1:0] {
        MODE_RATE,
        MODE_ROOT,
        MODE_BATCH
    } run_mode_t;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_RATE_SCALE  = 8'h04;
    localparam logic [7:0] OFS_BATCH_SCALE = 8'h08;
    localparam logic [7:0] OFS_TOTAL_SCALE = 8'h0c;
    localparam logic [7:0] OFS_RATE_OFFSET = 8'h10;
    localparam logic [7:0] OFS_STATUS      = 8'h14;
    localparam logic [7:0] OFS_DISP_MANT   = 8'h18;

    // Control field positions
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_AUTO_EN    = 2;
    localparam int CTRL_LEVEL_SEL  = 3;
    localparam int CTRL_LOCK_LSB   = 4;
    localparam int CTRL_AUTO_GO    = 8;

    // Status field positions
    localparam int STAT_SEL_LSB    = 0;
    localparam int STAT_LED_LSB    = 2;
    localparam int STAT_EXPO_ON    = 5;
    localparam int STAT_EXP_LSB    = 6;

    // Reset and auto scale values
    localparam run_mode_t   RST_MODE  = MODE_RATE;
    localparam logic [15:0] RST_SCALE = 16'h0001;
    localparam logic [31:0] RST_OFS   = 32'h0000_0000;
    localparam logic [15:0] AUTO_SCALE = 16'h0001;
    localparam logic [31:0] AUTO_OFS   = 32'h0000_0000;

    // Display formatting limits
    localparam logic [47:0] DISP_PLAIN_MAX = 48'd999999;
    localparam logic [47:0] MANT4_LIMIT    = 48'd10000;
    localparam logic [47:0] MANT3_LIMIT    = 48'd1000;
    localparam logic [4:0]  K4_LIMIT       = 5'd7;
    localparam logic [4:0]  EXP4_ADD       = 5'd3;
    localparam logic [4:0]  EXP3_ADD       = 5'd2;

    // Rate gate time: one second gives pulses per second
    localparam int CLK_HZ       = 10_000_000;
    localparam int GATE_MS      = 1000;
    localparam int GATE_CYCLES  = CLK_HZ / 1000 * GATE_MS;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== rtl/meter_core.sv
// Measurement selection, scaling, offset and display formatting core
`timescale 1ns/1ns
module meter_core #(
    parameter int unsigned GATE_CYCLES = meter_pkg::GATE_CYCLES
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_pulse,
    input  wire logic        i_disp_btn,
    input  wire logic        i_batch_done,
    input  wire logic        i_total_clr_n,
    input  wire logic [7:0]  i_s_awaddr,
    input  wire logic        i_s_awvalid,
    output logic             o_s_awready,
    input  wire logic [31:0] i_s_wdata,
    input  wire logic [3:0]  i_s_wstrb,
    input  wire logic        i_s_wvalid,
    output logic             o_s_wready,
    output logic [1:0]       o_s_bresp,
    output logic             o_s_bvalid,
    input  wire logic        i_s_bready,
    input  wire logic [7:0]  i_s_araddr,
    input  wire logic        i_s_arvalid,
    output logic             o_s_arready,
    output logic [31:0]      o_s_rdata,
    output logic [1:0]       o_s_rresp,
    output logic             o_s_rvalid,
    input  wire logic        i_s_rready,
    output logic [2:0]       o_meas_led,
    output logic [19:0]      o_disp_mant,
    output logic [4:0]       o_disp_exp,
    output logic             o_disp_expo_on
);

    typedef enum logic {
        DISP_LOAD,
        DISP_NORM
    } disp_state_t;

    meter_pkg::run_mode_t mode_r;
    logic        auto_en_r;
    logic        level_sel_r;
    logic [3:0]  lock_r;
    logic [15:0] rate_scale_r;
    logic [15:0] batch_scale_r;
    logic [15:0] total_scale_r;
    logic [31:0] rate_offset_r;
    logic [1:0]  sel_r;
    logic        aw_full_r;
    logic        w_full_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        pulse_prev_r;
    logic        btn_prev_r;
    logic        clr_prev_r;
    logic [31:0] gate_cnt_r;
    logic [31:0] rate_acc_r;
    logic [31:0] rate_raw_r;
    logic [31:0] avg_raw_r;
    logic [31:0] total_raw_r;
    logic [31:0] time_r;
    logic [31:0] batch_cnt_r;
    logic [31:0] batch_no_r;
    disp_state_t disp_state_r;
    logic [47:0] work_r;
    logic [4:0]  k_r;

    logic        wr_en;
    logic        wr_ctrl;
    logic        auto_go;
    logic [31:0] wr_word;
    logic        pulse_rise;
    logic        btn_press;
    logic        gate_end;
    logic        total_clr;
    logic [47:0] rate_scaled;
    logic [47:0] avg_scaled;
    logic [47:0] meas_value;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic is_mapped(input logic [7:0] a);
        return a == meter_pkg::OFS_CTRL || a == meter_pkg::OFS_RATE_SCALE
            || a == meter_pkg::OFS_BATCH_SCALE || a == meter_pkg::OFS_TOTAL_SCALE
            || a == meter_pkg::OFS_RATE_OFFSET || a == meter_pkg::OFS_STATUS
            || a == meter_pkg::OFS_DISP_MANT;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                res[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Next unlocked measurement, wrapping after the fourth
    function automatic logic [1:0] next_sel(input logic [1:0] cur, input logic [3:0] lock);
        logic [1:0] cand;
        logic [1:0] res;
        logic       found;
        res   = cur;
        found = 1'b0;
        cand  = cur;
        for (int i = 1; i < 5; i++) begin
            cand = cur + 2'(i);
            if (!found && !lock[cand]) begin
                res   = cand;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    function automatic logic [23:0] isqrt(input logic [47:0] v);
        logic [47:0] rem;
        logic [23:0] root;
        logic [25:0] trial;
        rem   = 48'h0;
        root  = 24'h0;
        trial = 26'h0;
        for (int i = 23; i >= 0; i--) begin
            rem   = {rem[45:0], v[2*i+1 -: 2]};
            trial = {root, 2'b01};
            if (rem >= {22'h0, trial}) begin
                rem  = rem - {22'h0, trial};
                root = {root[22:0], 1'b1};
            end else begin
                root = {root[22:0], 1'b0};
            end
        end
        return root;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    assign wr_en   = aw_full_r && w_full_r && !o_s_bvalid;
    assign wr_ctrl = wr_en && aw_addr_r == meter_pkg::OFS_CTRL;
    assign wr_word = merge(32'h0, w_data_r, w_strb_r);
    assign auto_go = wr_ctrl && w_strb_r[1] && w_data_r[meter_pkg::CTRL_AUTO_GO] && auto_en_r;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_s_awready <= 1'b0;
            o_s_wready  <= 1'b0;
            aw_full_r   <= 1'b0;
            w_full_r    <= 1'b0;
            aw_addr_r   <= 8'h00;
            w_data_r    <= 32'h0;
            w_strb_r    <= 4'h0;
            o_s_bvalid  <= 1'b0;
            o_s_bresp   <= meter_pkg::RESP_OKAY;
        end else begin
            if (!aw_full_r && !o_s_bvalid) begin
                o_s_awready <= !(i_s_awvalid && o_s_awready);
            end
            if (!w_full_r && !o_s_bvalid) begin
                o_s_wready <= !(i_s_wvalid && o_s_wready);
            end
            if (i_s_awvalid && o_s_awready) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= i_s_awaddr;
            end
            if (i_s_wvalid && o_s_wready) begin
                w_full_r <= 1'b1;
                w_data_r <= i_s_wdata;
                w_strb_r <= i_s_wstrb;
            end
            if (wr_en) begin
                aw_full_r  <= 1'b0;
                w_full_r   <= 1'b0;
                o_s_bvalid <= 1'b1;
                o_s_bresp  <= is_mapped(aw_addr_r) ? meter_pkg::RESP_OKAY
                                                   : meter_pkg::RESP_SLVERR;
            end
            if (o_s_bvalid && i_s_bready) begin
                o_s_bvalid  <= 1'b0;
                o_s_awready <= 1'b1;
                o_s_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_s_arready <= 1'b0;
            o_s_rvalid  <= 1'b0;
            o_s_rdata   <= 32'h0;
            o_s_rresp   <= meter_pkg::RESP_OKAY;
        end else if (o_s_rvalid) begin
            if (i_s_rready) begin
                o_s_rvalid  <= 1'b0;
                o_s_arready <= 1'b1;
            end
        end else if (i_s_arvalid && o_s_arready) begin
            o_s_arready <= 1'b0;
            o_s_rvalid  <= 1'b1;
            o_s_rresp   <= is_mapped(i_s_araddr) ? meter_pkg::RESP_OKAY
                                                 : meter_pkg::RESP_SLVERR;
            case (i_s_araddr)
                meter_pkg::OFS_CTRL:        o_s_rdata <= {24'h0, lock_r, level_sel_r, auto_en_r,
                                                          mode_r};
                meter_pkg::OFS_RATE_SCALE:  o_s_rdata <= {16'h0, rate_scale_r};
                meter_pkg::OFS_BATCH_SCALE: o_s_rdata <= {16'h0, batch_scale_r};
                meter_pkg::OFS_TOTAL_SCALE: o_s_rdata <= {16'h0, total_scale_r};
                meter_pkg::OFS_RATE_OFFSET: o_s_rdata <= rate_offset_r;
                meter_pkg::OFS_STATUS:      o_s_rdata <= {21'h0, o_disp_exp, o_disp_expo_on,
                                                          o_meas_led, sel_r};
                meter_pkg::OFS_DISP_MANT:   o_s_rdata <= {12'h0, o_disp_mant};
                default:                    o_s_rdata <= 32'h0;
            endcase
        end else begin
            o_s_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            mode_r      <= meter_pkg::RST_MODE;
            auto_en_r   <= 1'b0;
            level_sel_r <= 1'b0;
            lock_r      <= 4'h0;
        end else if (wr_ctrl && w_strb_r[0]) begin
            if (wr_word[1:0] != 2'b11) begin
                mode_r <= meter_pkg::run_mode_t'(wr_word[1:0]);
            end
            auto_en_r   <= wr_word[meter_pkg::CTRL_AUTO_EN];
            level_sel_r <= wr_word[meter_pkg::CTRL_LEVEL_SEL];
            lock_r      <= wr_word[meter_pkg::CTRL_LOCK_LSB +: 4];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rate_scale_r  <= meter_pkg::RST_SCALE;
            batch_scale_r <= meter_pkg::RST_SCALE;
            total_scale_r <= meter_pkg::RST_SCALE;
            rate_offset_r <= meter_pkg::RST_OFS;
        end else if (auto_go) begin
            rate_scale_r  <= meter_pkg::AUTO_SCALE;
            batch_scale_r <= meter_pkg::AUTO_SCALE;
            rate_offset_r <= meter_pkg::AUTO_OFS;
        end else if (wr_en) begin
            case (aw_addr_r)
                meter_pkg::OFS_RATE_SCALE:
                    rate_scale_r <= 16'(merge({16'h0, rate_scale_r}, w_data_r, w_strb_r));
                meter_pkg::OFS_BATCH_SCALE:
                    batch_scale_r <= 16'(merge({16'h0, batch_scale_r}, w_data_r, w_strb_r));
                meter_pkg::OFS_TOTAL_SCALE:
                    total_scale_r <= 16'(merge({16'h0, total_scale_r}, w_data_r, w_strb_r));
                meter_pkg::OFS_RATE_OFFSET:
                    rate_offset_r <= merge(rate_offset_r, w_data_r, w_strb_r);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Measurement selection and LEDs
    assign btn_press = i_disp_btn && !btn_prev_r;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            btn_prev_r <= 1'b0;
            sel_r      <= 2'd0;
            o_meas_led <= 3'b000;
        end else begin
            btn_prev_r <= i_disp_btn;
            if (wr_ctrl && w_strb_r[0] && wr_word[1:0] != 2'b11 && wr_word[1:0] != mode_r) begin
                sel_r <= 2'd0;
            end else if (btn_press) begin
                sel_r <= next_sel(sel_r, lock_r);
            end
            o_meas_led <= (sel_r == 2'd3) ? 3'b000 : 3'(3'b001 << sel_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse counting, rate gate, total, time and batch
    assign pulse_rise = i_pulse && !pulse_prev_r;
    assign gate_end   = gate_cnt_r == 32'(GATE_CYCLES - 1);
    assign total_clr  = level_sel_r ? !i_total_clr_n : (clr_prev_r && !i_total_clr_n);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pulse_prev_r <= 1'b0;
            gate_cnt_r   <= 32'h0;
            rate_acc_r   <= 32'h0;
            rate_raw_r   <= 32'h0;
            avg_raw_r    <= 32'h0;
            time_r       <= 32'h0;
        end else begin
            pulse_prev_r <= i_pulse;
            if (gate_end) begin
                gate_cnt_r <= 32'h0;
                rate_acc_r <= 32'h0;
                rate_raw_r <= rate_acc_r + {31'h0, pulse_rise};
                avg_raw_r  <= 32'(({1'b0, avg_raw_r} + {1'b0, rate_acc_r}) >> 1);
                time_r     <= time_r + 32'h1;
            end else begin
                gate_cnt_r <= gate_cnt_r + 32'h1;
                rate_acc_r <= rate_acc_r + {31'h0, pulse_rise};
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            clr_prev_r  <= 1'b1;
            total_raw_r <= 32'h0;
            batch_cnt_r <= 32'h0;
            batch_no_r  <= 32'h0;
        end else begin
            clr_prev_r <= i_total_clr_n;
            if (total_clr) begin
                total_raw_r <= 32'h0;
            end else begin
                total_raw_r <= total_raw_r + {31'h0, pulse_rise};
            end
            if (i_batch_done) begin
                batch_cnt_r <= {31'h0, pulse_rise};
                batch_no_r  <= batch_no_r + 32'h1;
            end else begin
                batch_cnt_r <= batch_cnt_r + {31'h0, pulse_rise};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scaled reading of the selected measurement
    assign rate_scaled = rate_raw_r * rate_scale_r + {16'h0, rate_offset_r};
    assign avg_scaled  = avg_raw_r * rate_scale_r + {16'h0, rate_offset_r};

    always_comb begin
        case (sel_r)
            2'd0: begin
                case (mode_r)
                    meter_pkg::MODE_ROOT:  meas_value = {24'h0, isqrt(rate_scaled)};
                    meter_pkg::MODE_BATCH: meas_value = batch_cnt_r * batch_scale_r;
                    default:               meas_value = rate_scaled;
                endcase
            end
            2'd1:    meas_value = (mode_r == meter_pkg::MODE_BATCH) ? {16'h0, batch_no_r}
                                                                    : avg_scaled;
            2'd2:    meas_value = total_raw_r * total_scale_r;
            default: meas_value = {16'h0, time_r};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Display formatter: plain up to six digits, else mantissa and exponent
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            disp_state_r   <= DISP_LOAD;
            work_r         <= 48'h0;
            k_r            <= 5'd0;
            o_disp_mant    <= 20'h0;
            o_disp_exp     <= 5'd0;
            o_disp_expo_on <= 1'b0;
        end else begin
            case (disp_state_r)
                DISP_LOAD: begin
                    work_r <= meas_value;
                    k_r    <= 5'd0;
                    if (meas_value <= meter_pkg::DISP_PLAIN_MAX) begin
                        o_disp_mant    <= meas_value[19:0];
                        o_disp_exp     <= 5'd0;
                        o_disp_expo_on <= 1'b0;
                    end else begin
                        disp_state_r <= DISP_NORM;
                    end
                end
                DISP_NORM: begin
                    if (work_r < meter_pkg::MANT4_LIMIT && k_r < meter_pkg::K4_LIMIT) begin
                        o_disp_mant    <= work_r[19:0];
                        o_disp_exp     <= k_r + meter_pkg::EXP4_ADD;
                        o_disp_expo_on <= 1'b1;
                        disp_state_r   <= DISP_LOAD;
                    end else if (work_r < meter_pkg::MANT3_LIMIT) begin
                        o_disp_mant    <= work_r[19:0];
                        o_disp_exp     <= k_r + meter_pkg::EXP3_ADD;
                        o_disp_expo_on <= 1'b1;
                        disp_state_r   <= DISP_LOAD;
                    end else begin
                        work_r <= work_r / 48'd10;
                        k_r    <= k_r + 5'd1;
                    end
                end
                default: disp_state_r <= DISP_LOAD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    reset_mode_a: assert property ($rose(i_rst_n) |-> mode_r == meter_pkg::MODE_RATE)
        else $error("mode not rate after reset");
    led_time_a: assert property (sel_r == 2'd3 |=> o_meas_led == 3'b000)
        else $error("led lit while time shown");
    led_top_a: assert property (sel_r == 2'd0 |=> o_meas_led == 3'b001)
        else $error("first measurement not on top led");
    btn_step_a: assert property (btn_press && lock_r == 4'h0 && !wr_ctrl
                                 |=> sel_r == $past(sel_r) + 2'd1)
        else $error("button did not step selection");
    lock_skip_a: assert property (btn_press && lock_r != 4'hf |=> !lock_r[sel_r])
        else $error("locked measurement selected");
    auto_zero_a: assert property (auto_go |=> rate_scale_r == 16'h0001
                                  && rate_offset_r == 32'h0)
        else $error("auto scale did not reset factors");
    auto_block_a: assert property (wr_ctrl && !auto_en_r |=> $stable(rate_scale_r))
        else $error("auto scale ran while disabled");
    clr_level_a: assert property (level_sel_r && !i_total_clr_n |=> total_raw_r == 32'h0)
        else $error("level clear missed");
    clr_idle_a: assert property (i_total_clr_n && !total_clr ##0 pulse_rise
                                 |=> total_raw_r == $past(total_raw_r) + 32'h1)
        else $error("total lost a pulse");
    exp_mant_a: assert property (o_disp_expo_on |-> o_disp_mant < 20'd10000
                                 && o_disp_exp >= 5'd6)
        else $error("exponential field too wide");
    plain_a: assert property (!o_disp_expo_on |-> o_disp_mant <= 20'd999999)
        else $error("plain field over six digits");
    norm_time_a: assert property (disp_state_r == DISP_NORM |-> ##[1:20]
                                  disp_state_r == DISP_LOAD)
        else $error("formatter stuck");

    wrap_c: cover property (sel_r == 2'd3 ##1 btn_press ##1 sel_r == 2'd0);
    expo_c: cover property (!o_disp_expo_on ##1 o_disp_expo_on);
    auto_c: cover property (auto_go);
    edge_clr_c: cover property (!level_sel_r && total_clr);

endmodule

// ===== bench/panel_model.sv
// Front panel model: pulse source, display button and total clear line
`timescale 1ns/1ns
module panel_model (
    input  wire logic i_clk,
    input  wire logic i_press,
    input  wire logic i_clr,
    output logic      o_pulse,
    output logic      o_btn,
    output logic      o_clr_n
);
    logic [1:0] ph_r = 2'h0;
    logic [1:0] hold_r = 2'h0;
    always_ff @(posedge i_clk) ph_r <= ph_r + 2'h1;
    // One rising edge every four clocks gives a known count per gate
    assign o_pulse = ph_r[1];
    always_ff @(posedge i_clk) hold_r <= i_press ? 2'h2 : hold_r - {1'b0, |hold_r};
    assign o_btn = |hold_r;
    assign o_clr_n = !i_clr;
endmodule

// ===== bench/meter_measurement_select_scale_bench.sv
// Self-checking bench of the measurement select and scale core
`timescale 1ns/1ns
module meter_measurement_select_scale_bench;
    logic clk = 1'b0, rst_n = 1'b0, press, pul, btn, clr_n;
    logic [7:0] aw, ar;
    logic [31:0] wd, rdat, d, seed;
    logic awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv, ok;
    logic [1:0] br, rr, r, sel;
    logic [3:0] m;
    logic [2:0] led;
    logic [19:0] em;
    logic [4:0] ee;
    logic eo, bd, clr;
    int errors = 0, cmp_count = 0;
    always #50 clk = ~clk;
    panel_model u_pm (.i_clk(clk), .i_press(press), .i_clr(clr), .o_pulse(pul), .o_btn(btn),
        .o_clr_n(clr_n));
    meter_core #(.GATE_CYCLES(20)) u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_pulse(pul),
        .i_disp_btn(btn), .i_batch_done(bd), .i_total_clr_n(clr_n), .i_s_awaddr(aw),
        .i_s_awvalid(awv), .o_s_awready(awr), .i_s_wdata(wd), .i_s_wstrb(4'hf),
        .i_s_wvalid(wv), .o_s_wready(wr_r), .o_s_bresp(br), .o_s_bvalid(bv),
        .i_s_bready(bry), .i_s_araddr(ar), .i_s_arvalid(arv), .o_s_arready(arr),
        .o_s_rdata(rdat), .o_s_rresp(rr), .o_s_rvalid(rv), .i_s_rready(rry),
        .o_meas_led(led), .o_disp_mant(), .o_disp_exp(), .o_disp_expo_on());
    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [1:0] nxt(input logic [1:0] s, input logic [3:0] k);
        logic [1:0] t;
        nxt = s;
        for (int j = 4; j >= 1; j--) begin
            t = s + 2'(j);
            if (!k[t]) nxt = t;
        end
    endfunction
    function logic [31:0] isq(input logic [31:0] v);
        isq = 0;
        while ((isq + 1) * (isq + 1) <= v) isq++;
    endfunction
    // Expected display: exponent is digit count less one, mantissa 4 digits up to E9, else 3
    task fmt(input logic [47:0] v);
        logic [47:0] t;
        int k;
        t = v;
        k = 0;
        while (t >= 48'd10) begin t = t / 48'd10; k++; end
        eo = v > 48'd999999;
        ee = eo ? 5'(k) : 5'd0;
        t = v;
        repeat (eo ? (k <= 9 ? k - 3 : k - 2) : 0) t = t / 48'd10;
        em = t[19:0];
    endtask
    task push;
        press <= 1;
        @(posedge clk);
        press <= 0;
        repeat (6) @(posedge clk);
    endtask
    task results;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        ok = 0;
        aw <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wr_r) wv <= 0;
            if (bv) begin bry <= 0; ok = 1; end
        end
        if (!ok) begin errors++; results; end
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a);
        ok = 0;
        ar <= a; arv <= 1; rry <= 1;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 0;
            if (rv) begin d = rdat; r = rr; rry <= 0; ok = 1; end
        end
        if (!ok) begin errors++; results; end
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {press, awv, wv, bry, arv, rry, bd, clr} = 0; aw = 0; ar = 0; wd = 0; seed = 32'h362c39cf;
        repeat (10) @(posedge clk);
        rst_n <= 1;
        rd(meter_pkg::OFS_CTRL); chk(d[1:0], 0);
        rd(meter_pkg::OFS_RATE_SCALE); chk(d, 1);
        seed = lfsr(seed);
        wr(meter_pkg::OFS_RATE_SCALE, {16'h0, seed[15:0]});
        rd(meter_pkg::OFS_RATE_SCALE); chk(d, {16'h0, seed[15:0]});
        wr(meter_pkg::OFS_TOTAL_SCALE, {16'h0, seed[31:16]});
        wr(meter_pkg::OFS_RATE_OFFSET, seed);
        wr(meter_pkg::OFS_CTRL, 32'h100);
        rd(meter_pkg::OFS_RATE_SCALE); chk(d, {16'h0, seed[15:0]});
        wr(meter_pkg::OFS_CTRL, 32'h4);
        wr(meter_pkg::OFS_CTRL, 32'h104);
        rd(meter_pkg::OFS_RATE_SCALE); chk(d, 1);
        rd(meter_pkg::OFS_RATE_OFFSET); chk(d, 0);
        rd(meter_pkg::OFS_TOTAL_SCALE); chk(d, {16'h0, seed[31:16]});
        rd(8'h40); chk({30'h0, r}, {30'h0, meter_pkg::RESP_SLVERR}); chk(d, 0);
        sel = 0; m = 0;
        for (int i = 0; i < 16; i++) begin
            if (i % 4 == 0 && i > 0) begin
                seed = lfsr(seed); m = seed[3:0];
                wr(meter_pkg::OFS_CTRL, {24'h0, m, 4'h4});
            end
            push;
            sel = nxt(sel, m);
            chk(led, sel == 3 ? 0 : 3'b001 << sel);
        end
        wr(meter_pkg::OFS_CTRL, 32'h5);
        wr(meter_pkg::OFS_CTRL, 32'h4);
        repeat (80) @(posedge clk);
        rd(meter_pkg::OFS_DISP_MANT); chk(d, 5);
        seed = lfsr(seed);
        wr(meter_pkg::OFS_RATE_SCALE, {16'h0, seed[15:0]});
        wr(meter_pkg::OFS_RATE_OFFSET, seed);
        repeat (30) @(posedge clk);
        fmt(48'd5 * seed[15:0] + {16'h0, seed});
        rd(meter_pkg::OFS_DISP_MANT); chk(d, {12'h0, em});
        rd(meter_pkg::OFS_STATUS); chk({26'h0, d[10:5]}, {26'h0, ee, eo});
        wr(meter_pkg::OFS_RATE_OFFSET, 0);
        wr(meter_pkg::OFS_CTRL, 32'h5);
        repeat (30) @(posedge clk);
        rd(meter_pkg::OFS_DISP_MANT); chk(d, isq(5 * seed[15:0]));
        wr(meter_pkg::OFS_CTRL, 32'h6);
        repeat (3) begin
            bd <= 1;
            @(posedge clk);
            bd <= 0;
            @(posedge clk);
        end
        push;
        chk(led, 3'b010);
        rd(meter_pkg::OFS_DISP_MANT); chk(d, 3);
        push;
        wr(meter_pkg::OFS_TOTAL_SCALE, 1);
        wr(meter_pkg::OFS_CTRL, 32'he);
        clr <= 1;
        repeat (10) @(posedge clk);
        rd(meter_pkg::OFS_DISP_MANT); chk(d, 0);
        clr <= 0;
        wr(meter_pkg::OFS_CTRL, 32'h6);
        repeat (200) @(posedge clk);
        clr <= 1;
        repeat (40) @(posedge clk);
        rd(meter_pkg::OFS_DISP_MANT); chk({31'h0, d != 0 && d < 32'd20}, 1);
        clr <= 0;
        results;
    end
endmodule
